// ### core/host_version_and_id_rom_access.sv
// version register and id rom access register with reset-time info load
`timescale 1ns/1ns
module host_version_and_id_rom_access (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  regAddr,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	input  wire logic [31:0] regWdata,
	output logic      [31:0] regRdata,
	output logic             regRdValid,
	input  wire logic        romDetect,
	output logic             romReq,
	output logic      [7:0]  romAddr,
	input  wire logic        romAck,
	input  wire logic [7:0]  romData,
	input  wire logic [4:0]  infoRdAddr,
	output logic      [7:0]  infoRdData,
	output logic             infoLoaded
);
	// whole state of the block in one record
	typedef struct packed {
		id_rom_pkg::ctrl_state_t st;
		logic                    detS1;
		logic                    detS2;
		logic [3:0]              settle;
		logic                    present;
		logic                    clearPend;
		logic                    readPend;
		logic [7:0]              readByte;
		logic [7:0]              byteAddr;
		logic [7:0]              loadIdx;
		logic                    loaded;
		logic                    fetchStart;
		logic                    memWe;
		logic [4:0]              memWaddr;
		logic [7:0]              memWdata;
		logic [31:0]             rdata;
		logic                    rdValid;
	} ctrl_t;

	ctrl_t c_r;
	ctrl_t c_nxt;

	logic       fetchBusy;
	logic       fetchDone;
	logic [7:0] fetchData;
	logic [7:0] fetchAddr;
	logic       romWrite;

	// version word: constant fields plus the present flag
	function automatic logic [31:0] version_word(input logic present);
		logic [31:0] w;
		w = id_rom_pkg::REG_ZERO;
		w[id_rom_pkg::POS_PRESENT] = present;
		w[id_rom_pkg::POS_MAJOR +: 8] = id_rom_pkg::VER_MAJOR;
		w[id_rom_pkg::POS_MINOR +: 8] = id_rom_pkg::VER_MINOR;
		return w;
	endfunction

	function automatic logic [31:0] rom_word(input logic clr,
		input logic rd, input logic [7:0] b);
		logic [31:0] w;
		w = id_rom_pkg::REG_ZERO;
		w[id_rom_pkg::POS_ADDR_CLEAR] = clr;
		w[id_rom_pkg::POS_READ_LAUNCH] = rd;
		w[id_rom_pkg::POS_READ_BYTE +: 8] = b;
		return w;
	endfunction

	// byte address after one completed transfer
	function automatic logic [7:0] step_addr(input logic [7:0] a);
		logic [7:0] n;
		n = a + 8'h01;
		return n;
	endfunction

	// read data for one register offset; unmapped offsets read zero
	function automatic logic [31:0] read_word(input logic [7:0] a,
		input ctrl_t c);
		logic [31:0] w;
		case (a)
			id_rom_pkg::OFS_VERSION:
			begin
				w = version_word(c.present);
			end
			id_rom_pkg::OFS_ROM_ACCESS:
			begin
				w = rom_word(c.clearPend, c.readPend, c.readByte);
			end
			default:
			begin
				w = id_rom_pkg::REG_ZERO;
			end
		endcase
		return w;
	endfunction

	always_comb
	begin
		c_nxt = c_r;
		// two-flop synchroniser on the detect pin
		c_nxt.detS1 = romDetect;
		c_nxt.detS2 = c_r.detS1;
		// strobes last a single cycle
		c_nxt.fetchStart = 1'b0;
		c_nxt.memWe = 1'b0;
		c_nxt.rdValid = 1'b0;

		case (c_r.st)
			// let the detect pin settle before trusting it
			id_rom_pkg::ST_SETTLE:
			begin
				if (c_r.settle == id_rom_pkg::DETECT_WAIT)
				begin
					c_nxt.present = c_r.detS2;
					c_nxt.loadIdx = id_rom_pkg::INFO_START;
					if (c_r.detS2)
					begin
						c_nxt.st = id_rom_pkg::ST_LOAD_REQ;
					end
					else
					begin
						c_nxt.st = id_rom_pkg::ST_IDLE;
					end
				end
				else
				begin
					c_nxt.settle = c_r.settle + 4'h1;
				end
			end
			// start one fetch of the reset-time load
			id_rom_pkg::ST_LOAD_REQ:
			begin
				if (!fetchBusy)
				begin
					c_nxt.fetchStart = 1'b1;
					c_nxt.st = id_rom_pkg::ST_LOAD_WAIT;
				end
			end
			// keep the fetched byte, then fetch the next or finish
			id_rom_pkg::ST_LOAD_WAIT:
			begin
				if (fetchDone)
				begin
					c_nxt.memWe = 1'b1;
					c_nxt.memWaddr = c_r.loadIdx[4:0];
					c_nxt.memWdata = fetchData;
					c_nxt.loadIdx = step_addr(c_r.loadIdx);
					if (c_r.loadIdx == id_rom_pkg::INFO_BYTES - 8'h01)
					begin
						c_nxt.loaded = 1'b1;
						c_nxt.byteAddr = id_rom_pkg::ROM_ADDR_RESET;
						c_nxt.st = id_rom_pkg::ST_IDLE;
					end
					else
					begin
						c_nxt.st = id_rom_pkg::ST_LOAD_REQ;
					end
				end
			end
			// a pending clear is served before a pending read
			id_rom_pkg::ST_IDLE:
			begin
				if (c_r.clearPend)
				begin
					c_nxt.st = id_rom_pkg::ST_CLEAR;
				end
				else if (c_r.readPend && !fetchBusy)
				begin
					c_nxt.fetchStart = 1'b1;
					c_nxt.st = id_rom_pkg::ST_READ_WAIT;
				end
			end
			// clear moves the address only and starts no fetch
			id_rom_pkg::ST_CLEAR:
			begin
				c_nxt.byteAddr = id_rom_pkg::ROM_ADDR_RESET;
				c_nxt.clearPend = 1'b0;
				c_nxt.st = id_rom_pkg::ST_IDLE;
			end
			// publish the byte and step to the next address
			id_rom_pkg::ST_READ_WAIT:
			begin
				if (fetchDone)
				begin
					c_nxt.readByte = fetchData;
					c_nxt.byteAddr = step_addr(c_r.byteAddr);
					c_nxt.readPend = 1'b0;
					c_nxt.st = id_rom_pkg::ST_IDLE;
				end
			end
			default:
			begin
				c_nxt.st = id_rom_pkg::ST_IDLE;
			end
		endcase

		// software sets come last so a set wins over a same-cycle clear
		if (romWrite)
		begin
			if (regWdata[id_rom_pkg::POS_ADDR_CLEAR])
			begin
				c_nxt.clearPend = 1'b1;
			end
			if (regWdata[id_rom_pkg::POS_READ_LAUNCH])
			begin
				c_nxt.readPend = 1'b1;
			end
		end

		// reads answer one cycle later from the registered word
		if (regRead)
		begin
			c_nxt.rdValid = 1'b1;
			c_nxt.rdata = read_word(regAddr, c_r);
		end
	end

	// synchronous reset to the start-up values, beginning in ST_SETTLE
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			c_r.st <= id_rom_pkg::ST_SETTLE;
			c_r.detS1 <= 1'b0;
			c_r.detS2 <= 1'b0;
			c_r.settle <= id_rom_pkg::SETTLE_RESET;
			c_r.present <= 1'b0;
			c_r.clearPend <= 1'b0;
			c_r.readPend <= 1'b0;
			c_r.readByte <= id_rom_pkg::BYTE_RESET;
			c_r.byteAddr <= id_rom_pkg::ROM_ADDR_RESET;
			c_r.loadIdx <= id_rom_pkg::INFO_START;
			c_r.loaded <= 1'b0;
			c_r.fetchStart <= 1'b0;
			c_r.memWe <= 1'b0;
			c_r.memWaddr <= id_rom_pkg::MEM_ADDR_RESET;
			c_r.memWdata <= id_rom_pkg::BYTE_RESET;
			c_r.rdata <= id_rom_pkg::REG_ZERO;
			c_r.rdValid <= 1'b0;
		end
		else
		begin
			c_r <= c_nxt;
		end
	end

	// the load walks its own index, software reads use the byte address
	assign fetchAddr = (c_r.st == id_rom_pkg::ST_READ_WAIT) ? c_r.byteAddr
		: c_r.loadIdx;
	// write strobe aimed at the rom access register
	assign romWrite = regWrite
		&& (regAddr == id_rom_pkg::OFS_ROM_ACCESS);

	// fetch engine for single rom bytes
	rom_byte_fetch u_fetch (
		.sys_clk (sys_clk),
		.rst     (rst),
		.start   (c_r.fetchStart),
		.addr    (fetchAddr),
		.busy    (fetchBusy),
		.done    (fetchDone),
		.data    (fetchData),
		.romReq  (romReq),
		.romAddr (romAddr),
		.romAck  (romAck),
		.romData (romData)
	);

	// host-side copy of the info block
	info_block_store u_store (
		.sys_clk (sys_clk),
		.rst     (rst),
		.wrEn    (c_r.memWe),
		.wrAddr  (c_r.memWaddr),
		.wrData  (c_r.memWdata),
		.rdAddr  (infoRdAddr),
		.rom_read_byte  (infoRdData)
	);

	// outputs come straight from flops
	assign regRdata = c_r.rdata;
	assign regRdValid = c_r.rdValid;
	assign infoLoaded = c_r.loaded;
endmodule

// ### core/id_rom_pkg.sv
// constants and types shared by the version and id rom access block
package id_rom_pkg;
	localparam logic [7:0] OFS_VERSION     = 8'h00;
	localparam logic [7:0] OFS_ROM_ACCESS  = 8'h04;
	localparam logic [7:0] VER_MAJOR       = 8'h01;
	localparam logic [7:0] VER_MINOR       = 8'h00;
	localparam int         POS_PRESENT     = 24;
	localparam int         POS_MAJOR       = 16;
	localparam int         POS_MINOR       = 0;
	localparam int         POS_ADDR_CLEAR  = 31;
	localparam int         POS_READ_LAUNCH = 25;
	localparam int         POS_READ_BYTE   = 16;
	localparam logic [31:0] REG_ZERO       = 32'h0000_0000;
	localparam logic [7:0] ROM_ADDR_RESET  = 8'h00;
	localparam logic [7:0] BYTE_RESET      = 8'h00;
	localparam logic [7:0] INFO_BYTES      = 8'h14;
	localparam logic [7:0] INFO_START      = 8'h00;
	localparam logic [3:0] DETECT_WAIT     = 4'h4;
	localparam logic [3:0] SETTLE_RESET    = 4'h0;
	localparam logic [4:0] MEM_ADDR_RESET  = 5'h00;
	localparam int         MEM_DEPTH       = 32;

	typedef enum logic [2:0] {
		ST_SETTLE,
		ST_LOAD_REQ,
		ST_LOAD_WAIT,
		ST_IDLE,
		ST_CLEAR,
		ST_READ_WAIT
	} ctrl_state_t;

	typedef enum logic [1:0] {
		FS_IDLE,
		FS_WAIT_HI,
		FS_WAIT_LO
	} fetch_state_t;
endpackage

// ### core/info_block_store.sv
// small memory holding the bus information block loaded at reset
`timescale 1ns/1ns
module info_block_store (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       wrEn,
	input  wire logic [4:0] wrAddr,
	input  wire logic [7:0] wrData,
	input  wire logic [4:0] rdAddr,
	output logic      [7:0] rom_read_byte
);
	typedef struct packed {
		logic [id_rom_pkg::MEM_DEPTH-1:0][7:0] mem;
		logic [7:0]                            rom_read_byte;
	} store_t;

	store_t store_r;
	store_t store_nxt;

	always_comb
	begin
		store_nxt = store_r;
		if (wrEn)
			store_nxt.mem[wrAddr] = wrData;
		store_nxt.rom_read_byte = store_r.mem[rdAddr];
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			store_r.rom_read_byte <= id_rom_pkg::BYTE_RESET;
		else
			store_r.rom_read_byte <= store_nxt.rom_read_byte;
		store_r.mem <= store_nxt.mem;
	end

	assign rom_read_byte = store_r.rom_read_byte;
endmodule

// ### core/rom_byte_fetch.sv
// four-phase handshake that fetches one byte from the serial rom reader
`timescale 1ns/1ns
module rom_byte_fetch (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       start,
	input  wire logic [7:0] addr,
	output logic            busy,
	output logic            done,
	output logic      [7:0] data,
	output logic            romReq,
	output logic      [7:0] romAddr,
	input  wire logic       romAck,
	input  wire logic [7:0] romData
);
	typedef struct packed {
		id_rom_pkg::fetch_state_t st;
		logic                     ackS1;
		logic                     ackS2;
		logic [7:0]               datS1;
		logic [7:0]               datS2;
		logic                     req;
		logic [7:0]               addr;
		logic [7:0]               data;
		logic                     done;
	} fetch_t;

	fetch_t f_r;
	fetch_t f_nxt;

	always_comb
	begin
		f_nxt = f_r;
		f_nxt.ackS1 = romAck;
		f_nxt.ackS2 = f_r.ackS1;
		f_nxt.datS1 = romData;
		f_nxt.datS2 = f_r.datS1;
		f_nxt.done = 1'b0;
		case (f_r.st)
			id_rom_pkg::FS_IDLE:
			begin
				if (start)
				begin
					f_nxt.req = 1'b1;
					f_nxt.addr = addr;
					f_nxt.st = id_rom_pkg::FS_WAIT_HI;
				end
			end
			id_rom_pkg::FS_WAIT_HI:
			begin
				if (f_r.ackS2)
				begin
					f_nxt.data = f_r.datS2;
					f_nxt.req = 1'b0;
					f_nxt.st = id_rom_pkg::FS_WAIT_LO;
				end
			end
			id_rom_pkg::FS_WAIT_LO:
			begin
				if (!f_r.ackS2)
				begin
					f_nxt.done = 1'b1;
					f_nxt.st = id_rom_pkg::FS_IDLE;
				end
			end
			default:
				f_nxt.st = id_rom_pkg::FS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			f_r.st <= id_rom_pkg::FS_IDLE;
			f_r.ackS1 <= 1'b0;
			f_r.ackS2 <= 1'b0;
			f_r.datS1 <= id_rom_pkg::BYTE_RESET;
			f_r.datS2 <= id_rom_pkg::BYTE_RESET;
			f_r.req <= 1'b0;
			f_r.addr <= id_rom_pkg::ROM_ADDR_RESET;
			f_r.data <= id_rom_pkg::BYTE_RESET;
			f_r.done <= 1'b0;
		end
		else
			f_r <= f_nxt;
	end

	assign busy = (f_r.st != id_rom_pkg::FS_IDLE);
	assign done = f_r.done;
	assign data = f_r.data;
	assign romReq = f_r.req;
	assign romAddr = f_r.addr;
endmodule

// ### tb/rom_model.sv
// behavioural serial id rom answering byte fetch requests
`timescale 1ns/1ns
module rom_model (
	input  wire logic       sys_clk,
	input  wire logic       romReq,
	input  wire logic [7:0] romAddr,
	input  wire logic [3:0] lag,
	output logic            romAck,
	output logic      [7:0] romData
);
	logic       ack_r = 1'b0;
	logic [7:0] data_r = 8'h00;
	logic [3:0] cnt_r = 4'h0;
	assign romAck = ack_r;
	assign romData = data_r;
	// byte at address a is a ^ 8'h5a; data churns while released
	always_ff @(posedge sys_clk)
	begin
		if (!romReq)
		begin
			cnt_r <= 4'h0;
			ack_r <= 1'b0;
			data_r <= ~data_r;
		end
		else if (cnt_r < lag)
			cnt_r <= cnt_r + 4'h1;
		else
		begin
			ack_r <= 1'b1;
			data_r <= romAddr ^ 8'h5a;
		end
	end
endmodule

// ### tb/host_version_and_id_rom_access_chk.sv
// assertions on the version and id rom access ports
`timescale 1ns/1ns
module host_version_and_id_rom_access_chk (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic [7:0]  regAddr,
	input wire logic        regRead,
	input wire logic [31:0] regRdata,
	input wire logic        regRdValid,
	input wire logic        romReq,
	input wire logic [7:0]  romAddr,
	input wire logic        romAck,
	input wire logic        infoLoaded
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence rd_ver;
		regRead && regAddr == 8'h00;
	endsequence
	sequence rd_rom;
		regRead && regAddr == 8'h04;
	endsequence
	ver_fields_a: assert property (rd_ver |=>
		regRdata[23:0] == 24'h01_0000 && regRdata[31:25] == 7'h00)
		else $error("version fields wrong");
	present_flag_a: assert property (
		infoLoaded && regRead && regAddr == 8'h00 |=> regRdata[24])
		else $error("present flag low after load");
	rom_rsvd_a: assert property (rd_rom |=>
		regRdata[30:26] == 5'h00 && !regRdata[24]
		&& regRdata[15:0] == 16'h0000)
		else $error("rom word reserved bits set");
	rd_valid_a: assert property (regRead |=> regRdValid)
		else $error("read answer missing");
	req_hold_a: assert property ($rose(romReq) |=> romReq[*2])
		else $error("fetch request dropped early");
	addr_stable_a: assert property (
		romReq && $past(romReq) |-> $stable(romAddr))
		else $error("fetch address moved");
	req_drop_a: assert property ($rose(romAck) |-> ##[1:6] !romReq)
		else $error("fetch request not released");
	req_gap_a: assert property ($fell(romReq) |=> !romReq[*3])
		else $error("fetches overlap");
endmodule
bind host_version_and_id_rom_access host_version_and_id_rom_access_chk
	i_chk (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
	.regRead(regRead), .regRdata(regRdata), .regRdValid(regRdValid),
	.romReq(romReq), .romAddr(romAddr), .romAck(romAck),
	.infoLoaded(infoLoaded));

// ### tb/host_version_and_id_rom_access_tb.sv
// self-checking bench for the version and id rom access block
`timescale 1ns/1ns
module host_version_and_id_rom_access_tb;
	logic        sys_clk = 0;
	logic        rst = 1;
	logic [7:0]  regAddr = 8'h00;
	logic        regWrite = 0;
	logic        regRead = 0;
	logic [31:0] regWdata = 32'h0000_0000;
	logic [31:0] regRdata;
	logic        regRdValid;
	logic        romDetect = 1;
	logic        romReq;
	logic [7:0]  romAddr;
	logic        romAck;
	logic [7:0]  romData;
	logic [4:0]  infoRdAddr = 5'h00;
	logic [7:0]  infoRdData;
	logic        infoLoaded;
	logic [3:0]  lag = 4'h0;
	logic [31:0] w;
	int          n_errors = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	typedef struct {logic [7:0] a; logic [31:0] e;} row_t;
	row_t rows [3] = '{'{8'h00, 32'h0101_0000},
		'{8'h08, 32'h0000_0000}, '{8'h0c, 32'h0000_0000}};
	host_version_and_id_rom_access i_dut (.sys_clk(sys_clk), .rst(rst),
		.regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
		.regWdata(regWdata), .regRdata(regRdata),
		.regRdValid(regRdValid), .romDetect(romDetect),
		.romReq(romReq), .romAddr(romAddr), .romAck(romAck),
		.romData(romData), .infoRdAddr(infoRdAddr),
		.infoRdData(infoRdData), .infoLoaded(infoLoaded));
	rom_model i_rom (.sys_clk(sys_clk), .romReq(romReq),
		.romAddr(romAddr), .lag(lag), .romAck(romAck),
		.romData(romData));
	always #4 sys_clk = ~sys_clk;
	task report_and_stop;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			report_and_stop;
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("FAIL %s exp %h got %h", nm, e, g);
		end
	endtask
	task rd(input logic [7:0] a);
		@(posedge sys_clk);
		regAddr <= a;
		regRead <= 1;
		@(posedge sys_clk);
		regRead <= 0;
		#1 w = regRdata;
		chk("valid", 1, regRdValid);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1;
		@(posedge sys_clk);
		regWrite <= 0;
	endtask
	task poll(input int b);
		for (int i = 0; i < 100; i++)
		begin
			rd(8'h04);
			if (w[b] === 1'b0)
				break;
		end
	endtask
	task fetch(input logic [7:0] e);
		wr(8'h04, 32'h0200_0000);
		poll(25);
		chk("byte", {8'h00, e, 16'h0000}, w);
	endtask
	initial
	begin
		repeat (4) @(posedge sys_clk);
		rst <= 0;
		rd(8'h00);
		chk("early", 32'h0001_0000, w);
		for (int i = 0; i < 3000 && infoLoaded !== 1'b1; i++)
			@(posedge sys_clk);
		chk("loaded", 1, infoLoaded);
		for (int i = 0; i < 20; i++)
		begin
			@(posedge sys_clk);
			infoRdAddr <= i[4:0];
			@(posedge sys_clk);
			#1 chk("info", {24'h0, i[7:0] ^ 8'h5a}, infoRdData);
		end
		wr(8'h00, 32'hffff_ffff);
		foreach (rows[i])
		begin
			rd(rows[i].a);
			chk("reg", rows[i].e, w);
		end
		fetch(8'h5a);
		lag <= 4'h5;
		fetch(8'h5b);
		wr(8'h04, 32'h8000_0000);
		poll(31);
		chk("clear", 32'h005b_0000, w);
		fetch(8'h5a);
		wr(8'h04, 32'h0200_0000);
		@(posedge sys_clk);
		rst <= 1;
		romDetect <= 0;
		repeat (4) @(posedge sys_clk);
		rst <= 0;
		repeat (8) @(posedge sys_clk);
		rd(8'h00);
		chk("absent", 32'h0001_0000, w);
		rd(8'h04);
		chk("rom", 32'h0000_0000, w);
		chk("noload", 0, infoLoaded);
		report_and_stop;
	end
endmodule
